// ===== bench/pm_link_checker.sv
// Purpose: Timing checks on the low-power link between the two ends
// Assumes: One clock; link signals seen as plain inputs
// Notes: Halt lands four cycles after an accepted entry
`timescale 1ns/100ps
module pm_link_checker
  import pm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic regWr,
  input wire logic [1:0] regSel,
  input wire logic [7:0] regData,
  input wire logic waitInstr,
  input wire logic [2:0] processor_priority_level,
  input wire logic iFlag,
  input wire logic irqPend,
  input wire logic [2:0] irqLevel,
  input wire logic nmiPend,
  input wire logic dummyInt,
  input wire logic [2:0] threshold,
  input wire logic coreHalted,
  input wire logic wakeEvt,
  input wire logic wokeNmi,
  input wire logic [1:0] lowMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Steps of entry and wake
  sequence stopWr_s;
    regWr && regSel == SEL_CLKMODE1 && regData[CM1_STOP_BIT];
  endsequence
  sequence quiet_s;
    !regWr && !waitInstr;
  endsequence
  sequence resumed_s;
    !coreHalted && wakeEvt;
  endsequence
  // Threshold register and entry order
  thr_reset_a: assert property ($rose(rstn) |-> threshold == THRESHOLD_RESET)
    else $error("threshold not 7 after reset");
  thr_write_a: assert property (regWr && regSel == SEL_THRESHOLD |=>
    threshold == $past(regData[2:0])) else $error("threshold write lost");
  thr_ipl_a: assert property (regWr && regSel == SEL_THRESHOLD && regData != 8'h07
    |-> regData[2:0] == processor_priority_level) else $error("threshold differs from level");
  iflag_stop_a: assert property (stopWr_s |-> iFlag)
    else $error("stop entered with interrupts disabled");
  stop_halt_a: assert property (stopWr_s |-> ##4 (coreHalted && lowMode == 2'b11))
    else $error("stop halt late");
  wait_halt_a: assert property (waitInstr |-> ##4 (coreHalted && lowMode == 2'b01))
    else $error("wait halt late");
  wait_nops_a: assert property (waitInstr |=> quiet_s [*4])
    else $error("activity in wait slots");
  stop_jump_a: assert property (stopWr_s |=> quiet_s [*5])
    else $error("activity in stop slots");
  irq_wake_a: assert property (coreHalted && iFlag && irqPend && irqLevel > threshold
    |=> resumed_s) else $error("qualifying interrupt did not wake");
  hold_halt_a: assert property (coreHalted && !nmiPend &&
    !(iFlag && irqPend && irqLevel > threshold) |=> coreHalted) else $error("spurious wake");
  nmi_wake_a: assert property (coreHalted && nmiPend |=> resumed_s ##0 wokeNmi)
    else $error("nmi wake wrong");
  restore_a: assert property (coreHalted ##1 wakeEvt |-> ##[1:4]
    (regWr && regSel == SEL_THRESHOLD && regData == 8'h07)) else $error("no restore");
  dummy_a: assert property (stopWr_s |-> !wokeNmi)
    else $error("restop without dummy interrupt");
endmodule // pm_link_checker

// ===== bench/stop_wait_mode_control_tb.sv
// Purpose: Self-checking bench for both ends of the low-power link
// Assumes: Software side reached over AXI4-Lite
// Notes: Status polled with a bounded loop
`timescale 1ns/100ps
module stop_wait_mode_control_tb
  import pm_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sysClkEn, cpuClkEn, stopActive;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, st;
  int n_fail = 0;
  int tests_run = 0;
  // Clock and both ends
  always #50 clk = ~clk;
  pm_link lnk();
  pm_device_end pm_device_end_i (.clk(clk), .rstn(rstn), .lnk(lnk.device_mp),
    .sysClkEn(sysClkEn), .cpuClkEn(cpuClkEn), .stopActive(stopActive));
  pm_core_end pm_core_end_i (.clk(clk), .rstn(rstn), .lnk(lnk.core_mp), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  pm_link_checker pm_link_checker_i (.clk(clk), .rstn(rstn), .regWr(lnk.regWr),
    .regSel(lnk.regSel), .regData(lnk.regData), .waitInstr(lnk.waitInstr), .processor_priority_level(lnk.processor_priority_level),
    .iFlag(lnk.iFlag), .irqPend(lnk.irqPend), .irqLevel(lnk.irqLevel), .nmiPend(lnk.nmiPend),
    .dummyInt(lnk.dummyInt), .threshold(lnk.threshold), .coreHalted(lnk.coreHalted),
    .wakeEvt(lnk.wakeEvt), .wokeNmi(lnk.wokeNmi), .lowMode(lnk.lowMode));
  // Verdict, comparison and timeout
  task finish_test;
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task tmo;
    n_fail++;
    $display("wrong value at %0t: wait ran out", $time);
    finish_test();
  endtask
  // Bus write: address and data together, bready held until bvalid
  task axw(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 50) tmo();
    rsp = bresp;
    bready <= 1'b0;
  endtask
  // Bus read into st
  task axr(input logic [7:0] a);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 50) tmo();
    st = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task waitst(input logic [31:0] m, input logic [31:0] v);
    int i;
    for (i = 0; i < 100; i++) begin
      axr(OFF_STATUS);
      if ((st & m) === v) break;
    end
    if (i == 100) tmo();
  endtask
  task clocks(input logic [2:0] e);
    chk(32'({sysClkEn, cpuClkEn, stopActive}), 32'(e));
  endtask
  // Reset values
  task t_reset;
    axr(OFF_STATUS);
    chk(st & 32'h37e0, 32'h0700);
    clocks(3'b110);
    axr(OFF_LEVELS);
    chk(st, 32'h0);
  endtask
  // Wait entry with a non-waking interrupt pending, then wake
  task t_wait;
    axw(OFF_LEVELS, 32'h325);
    chk(32'(rsp), 32'(RESP_OKAY));
    axw(OFF_IRQ, 32'h2);
    axw(OFF_CTRL, 32'h1);
    waitst(32'h20, 32'h20);
    chk(st & 32'h7700, 32'h5300);
    clocks(3'b100);
    repeat (10) @(posedge clk);
    axr(OFF_STATUS);
    chk(st & 32'h20, 32'h20);
    axw(OFF_IRQ, 32'h3);
    waitst(32'ha0, 32'h0);
    chk(st & 32'h3700, 32'h0700);
    clocks(3'b110);
    axw(OFF_IRQ, 32'h0);
  endtask
  // Stop, NMI wake, restop through the dummy interrupt
  task t_stop;
    axw(OFF_CTRL, 32'h2);
    waitst(32'h20, 32'h20);
    chk(st & 32'h3000, 32'h3000);
    clocks(3'b001);
    axw(OFF_IRQ, 32'h4);
    waitst(32'ha0, 32'h0);
    chk(st & 32'h0740, 32'h0740);
    axw(OFF_CTRL, 32'h2);
    waitst(32'h20, 32'h20);
    chk(st & 32'h3f0040, 32'h3f0000);
    axw(OFF_IRQ, 32'h2);
    repeat (10) @(posedge clk);
    axr(OFF_STATUS);
    chk(st & 32'h20, 32'h20);
    axw(OFF_IRQ, 32'h3);
    waitst(32'ha0, 32'h0);
    clocks(3'b110);
    axw(OFF_IRQ, 32'h0);
  endtask
  // Unmapped and write-only places
  task t_bus;
    axw(8'h10, 32'h1);
    chk(32'(rsp), 32'(RESP_SLVERR));
    axr(8'h10);
    chk(st, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    axr(OFF_CTRL);
    chk(st, 32'h0);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_wait();
    t_stop();
    t_bus();
    finish_test();
  end
endmodule // stop_wait_mode_control_tb

// ===== hdl/pm_core_end.sv
// Purpose: Core and interrupt controller end of the low-power link
// Assumes: Software drives it over AXI4-Lite; same clk as the device
// Notes: Runs the entry, prefetch guard and exit sequence in hardware
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module pm_core_end
  import pm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  pm_link.core_mp lnk,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  core_state_t state;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [10:0] levels;
  logic [1:0] irqReq;
  logic [2:0] nopCnt, prioWake, prioOther;
  logic [5:0] lastVector;
  logic awHeld, wHeld, wrFire, goStop, woke, orderOk, cmdWait, cmdStop;

  // Address decode shared by both channels
  function automatic logic isMapped(input logic [7:0] a);
    return a == OFF_CTRL || a == OFF_LEVELS || a == OFF_IRQ || a == OFF_STATUS;
  endfunction

  assign wrFire = awHeld && wHeld && !bvalid;
  assign cmdWait = wrFire && awAddr == OFF_CTRL && wStrb[0] && wData[CTRL_WAIT_BIT];
  assign cmdStop = wrFire && awAddr == OFF_CTRL && wStrb[0] && wData[CTRL_STOP_BIT];
  // Waking level strictly above the level, non-waking at or below
  assign orderOk = prioWake > lnk.processor_priority_level && lnk.processor_priority_level >= prioOther;

  // AXI write address, data and response channels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0;
      wStrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awAddr <= awaddr;
        awHeld <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wData <= wdata;
        wStrb <= wstrb;
        wHeld <= 1'b1;
        wready <= 1'b0;
      end
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // AXI read channel
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      if (araddr == OFF_LEVELS) begin
        rdata <= {21'h0, levels};
      end else if (araddr == OFF_IRQ) begin
        rdata <= {30'h0, irqReq};
      end else if (araddr == OFF_STATUS) begin
        rdata <= {10'h0, lastVector, 1'b0, orderOk, lnk.lowMode, 1'b0,
                  lnk.threshold, state != ST_IDLE, lnk.wokeNmi,
                  lnk.coreHalted, 1'b0, state};
      end else begin
        rdata <= 32'h0;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Software-held levels and interrupt requests
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      levels <= LEVELS_RESET;
      irqReq <= 2'b00;
      lnk.nmiPend <= 1'b0;
    end else begin
      lnk.nmiPend <= wrFire && awAddr == OFF_IRQ && wStrb[0] && wData[IRQ_NMI_BIT];
      if (wrFire && awAddr == OFF_LEVELS && wStrb[0]) begin
        levels[7:0] <= wData[7:0]; // Byte lane 0: both priorities
      end
      if (wrFire && awAddr == OFF_LEVELS && wStrb[1]) begin
        levels[10:8] <= wData[10:8]; // Byte lane 1: processor level
      end
      if (wrFire && awAddr == OFF_IRQ && wStrb[0]) begin
        irqReq <= {wData[IRQ_OTHER_BIT], wData[IRQ_WAKE_BIT]};
      end
    end
  end

  // Interrupt controller: highest pending level goes to the device
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lnk.irqPend <= 1'b0;
      lnk.irqLevel <= 3'h0;
    end else begin
      lnk.irqPend <= |irqReq;
      if (irqReq[0] && (!irqReq[1] || prioWake >= prioOther)) begin
        lnk.irqLevel <= prioWake;
      end else if (irqReq[1]) begin
        lnk.irqLevel <= prioOther;
      end else begin
        lnk.irqLevel <= 3'h0;
      end
    end
  end

  // Entry and exit sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      goStop <= 1'b0;
      woke <= 1'b0;
      nopCnt <= 3'h0;
      prioWake <= 3'h0;
      prioOther <= 3'h0;
      lastVector <= 6'h00;
      lnk.processor_priority_level <= 3'h0;
      lnk.iFlag <= 1'b0;
      lnk.regWr <= 1'b0;
      lnk.regSel <= SEL_THRESHOLD;
      lnk.regData <= 8'h00;
      lnk.waitInstr <= 1'b0;
      lnk.dummyInt <= 1'b0;
    end else begin
      lnk.regWr <= 1'b0;
      lnk.waitInstr <= 1'b0;
      lnk.dummyInt <= 1'b0;
      if (lnk.wakeEvt) begin
        woke <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          woke <= 1'b0;
          nopCnt <= 3'h0;
          if (cmdWait || cmdStop) begin
            goStop <= cmdStop;
            state <= ST_PRIO;
          end
        end
        ST_PRIO: begin
          prioWake <= levels[LV_WAKE_LSB +: 3];
          state <= ST_IPL;
        end
        ST_IPL: begin
          prioOther <= levels[LV_OTHER_LSB +: 3];
          lnk.processor_priority_level <= levels[LV_IPL_LSB +: 3];
          state <= ST_THR;
        end
        ST_THR: begin
          lnk.regWr <= 1'b1;
          lnk.regSel <= SEL_THRESHOLD;
          lnk.regData <= {5'h00, lnk.processor_priority_level};
          state <= ST_IFLAG;
        end
        ST_IFLAG: begin
          lnk.iFlag <= 1'b1;
          state <= (goStop && lnk.wokeNmi) ? ST_DUMMY : (goStop ? ST_UNLOCK : ST_ENTER);
        end
        ST_DUMMY: begin
          lnk.dummyInt <= 1'b1;
          lastVector <= DUMMY_VECTOR;
          state <= ST_UNLOCK;
        end
        ST_UNLOCK: begin
          lnk.regWr <= 1'b1;
          lnk.regSel <= SEL_PROTECT;
          lnk.regData <= 8'h01;
          state <= ST_ENTER;
        end
        ST_ENTER: begin
          if (goStop) begin
            lnk.regWr <= 1'b1;
            lnk.regSel <= SEL_CLKMODE1;
            lnk.regData <= 8'h01;
            state <= ST_JUMP;
          end else begin
            lnk.waitInstr <= 1'b1;
            state <= ST_NOPS;
          end
        end
        ST_JUMP: begin
          state <= ST_NOPS;
        end
        ST_NOPS: begin
          // No-op slots only retire while the core is running
          if (!lnk.coreHalted) begin
            nopCnt <= nopCnt + 3'h1;
          end
          if (nopCnt == NOP_MIN - 3'h1 && !lnk.coreHalted) begin
            state <= (woke || lnk.wakeEvt) ? ST_RESTORE : ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (lnk.wakeEvt) begin
            state <= ST_RESTORE;
          end
        end
        ST_RESTORE: begin
          lnk.regWr <= 1'b1;
          lnk.regSel <= SEL_THRESHOLD;
          lnk.regData <= {5'h00, THRESHOLD_RESET};
          state <= goStop ? ST_RELOCK : ST_IDLE;
        end
        ST_RELOCK: begin
          lnk.regWr <= 1'b1;
          lnk.regSel <= SEL_PROTECT;
          lnk.regData <= 8'h00;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // pm_core_end

// ===== hdl/pm_device_end.sv
// Purpose: Stop/wait mode controller facing the clock generator
// Assumes: Core end keeps the software-side entry and exit procedure
// Notes: Halt lands a few cycles after entry to model queue prefetch
`timescale 1ns/100ps
module pm_device_end
  import pm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  pm_link.device_mp lnk,
  output logic sysClkEn,
  output logic cpuClkEn,
  output logic stopActive
);
  mode_t mode;
  logic unlock;
  logic lowStop;
  logic [1:0] lag;
  logic stopReq;
  logic wakeReq;

  // Stop write honoured only while clock writes are unlocked
  assign stopReq = lnk.regWr && lnk.regSel == SEL_CLKMODE1 &&
                   lnk.regData[CM1_STOP_BIT] && unlock;
  // Qualifying interrupt or the non-maskable one
  assign wakeReq = lnk.nmiPend ||
                   (lnk.iFlag && lnk.irqPend && lnk.irqLevel > lnk.threshold);

  // Wake threshold and protect registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lnk.threshold <= THRESHOLD_RESET;
      unlock <= 1'b0;
    end else if (lnk.regWr) begin
      if (lnk.regSel == SEL_THRESHOLD) begin
        lnk.threshold <= lnk.regData[2:0];
      end else if (lnk.regSel == SEL_PROTECT) begin
        unlock <= lnk.regData[PROTECT_CLK_BIT];
      end
    end
  end

  // Mode sequence: run, drain of prefetched slots, low power
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode <= MODE_RUN;
      lowStop <= 1'b0;
      lag <= 2'h0;
      lnk.coreHalted <= 1'b0;
      lnk.wakeEvt <= 1'b0;
      sysClkEn <= 1'b1;
      cpuClkEn <= 1'b1;
      stopActive <= 1'b0;
    end else begin
      lnk.wakeEvt <= 1'b0;
      case (mode)
        MODE_RUN: begin
          lag <= 2'h0;
          if (stopReq) begin
            mode <= MODE_DRAIN;
            lowStop <= 1'b1;
          end else if (lnk.waitInstr) begin
            mode <= MODE_DRAIN;
            lowStop <= 1'b0;
          end
        end
        MODE_DRAIN: begin
          // Queued instructions keep executing until the halt lands
          lag <= lag + 2'h1;
          if (wakeReq) begin
            mode <= MODE_RUN;
            lnk.wakeEvt <= 1'b1;
          end else if (lag == PREFETCH_LAG - 2'h1) begin
            mode <= MODE_LOW;
            lnk.coreHalted <= 1'b1;
            cpuClkEn <= 1'b0;
            sysClkEn <= ~lowStop;
            stopActive <= lowStop;
          end
        end
        MODE_LOW: begin
          if (wakeReq) begin
            mode <= MODE_RUN;
            lnk.coreHalted <= 1'b0;
            lnk.wakeEvt <= 1'b1;
            cpuClkEn <= 1'b1;
            sysClkEn <= 1'b1;
            stopActive <= 1'b0;
          end
        end
        default: begin
          mode <= MODE_RUN;
        end
      endcase
    end
  end

  // Mode code seen by the core: 00 run, 01 wait, 11 stop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lnk.lowMode <= 2'b00;
    end else if (stopReq && mode == MODE_RUN) begin
      lnk.lowMode <= 2'b11;
    end else if (lnk.waitInstr && mode == MODE_RUN) begin
      lnk.lowMode <= 2'b01;
    end else if (wakeReq && mode != MODE_RUN) begin
      lnk.lowMode <= 2'b00;
    end
  end

  // Non-maskable wake flag; cleared by the dummy interrupt, set wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lnk.wokeNmi <= 1'b0;
    end else if (wakeReq && mode != MODE_RUN && lnk.nmiPend) begin
      lnk.wokeNmi <= 1'b1;
    end else if (lnk.dummyInt) begin
      lnk.wokeNmi <= 1'b0;
    end
  end
endmodule // pm_device_end

// ===== hdl/pm_link.sv
// Purpose: Link between core/interrupt controller and the mode controller
// Assumes: Both ends run on the same clk
// Notes: All signals are registered by their driver
`timescale 1ns/100ps
interface pm_link;
  logic regWr;
  logic [1:0] regSel;
  logic [7:0] regData;
  logic waitInstr;
  logic [2:0] processor_priority_level;
  logic iFlag;
  logic irqPend;
  logic [2:0] irqLevel;
  logic nmiPend;
  logic dummyInt;
  logic [2:0] threshold;
  logic coreHalted;
  logic wakeEvt;
  logic wokeNmi;
  logic [1:0] lowMode;

  modport device_mp (
    input regWr, regSel, regData, waitInstr, processor_priority_level, iFlag, irqPend, irqLevel,
    input nmiPend, dummyInt,
    output threshold, coreHalted, wakeEvt, wokeNmi, lowMode
  );
  modport core_mp (
    output regWr, regSel, regData, waitInstr, processor_priority_level, iFlag, irqPend, irqLevel,
    output nmiPend, dummyInt,
    input threshold, coreHalted, wakeEvt, wokeNmi, lowMode
  );
endinterface

// ===== hdl/pm_pkg.sv
// Purpose: Shared constants and types for the stop/wait mode controller
// Assumes: One clock domain; both ends on the same clk
// Notes: Link select codes address the device's own registers
package pm_pkg;
  // Device registers reached over the link
  localparam logic [1:0] SEL_THRESHOLD = 2'h0;
  localparam logic [1:0] SEL_CLKMODE1 = 2'h1;
  localparam logic [1:0] SEL_PROTECT = 2'h2;
  localparam int CM1_STOP_BIT = 0;
  localparam int PROTECT_CLK_BIT = 0;
  localparam logic [2:0] THRESHOLD_RESET = 3'h7;
  // Prefetch and instruction-slot counts
  localparam logic [1:0] PREFETCH_LAG = 2'h3;
  localparam logic [2:0] NOP_MIN = 3'h4;
  localparam logic [5:0] DUMMY_VECTOR = 6'h3f;
  // Core-end register offsets (AXI4-Lite, byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LEVELS = 8'h04;
  localparam logic [7:0] OFF_IRQ = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  // Field positions
  localparam int CTRL_WAIT_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int LV_WAKE_LSB = 0;
  localparam int LV_OTHER_LSB = 4;
  localparam int LV_IPL_LSB = 8;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_OTHER_BIT = 1;
  localparam int IRQ_NMI_BIT = 2;
  localparam logic [10:0] LEVELS_RESET = 11'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_DRAIN = 2'b01,
    MODE_LOW = 2'b11
  } mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_PRIO = 4'b0001,
    ST_IPL = 4'b0011,
    ST_THR = 4'b0010,
    ST_IFLAG = 4'b0110,
    ST_DUMMY = 4'b0111,
    ST_UNLOCK = 4'b0101,
    ST_ENTER = 4'b0100,
    ST_JUMP = 4'b1100,
    ST_NOPS = 4'b1101,
    ST_SLEEP = 4'b1111,
    ST_RESTORE = 4'b1110,
    ST_RELOCK = 4'b1010
  } core_state_t;
endpackage
